// File: bench/cdp_datapath_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// bus handshake checker
// --------------------------------
module cdp_datapath_asserts #(
  parameter int DIV_W = 16  // divide length, handed on by the bind
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // address and data taken together, and a read address taken
  sequence s_wt; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rt; s_axi_arvalid && s_axi_arready; endsequence
  a_write_stall: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  a_read_stall: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while data pending");
  a_write_answer: assert property (s_wt |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rt |=> s_axi_rvalid)
    else $error("read data late");
  a_write_cause: assert property (!s_axi_bvalid && !s_axi_awvalid && !s_axi_wvalid |=> !s_axi_bvalid)
    else $error("write response without request");
  a_read_cause: assert property (!s_axi_rvalid && !s_axi_arvalid |=> !s_axi_rvalid)
    else $error("read data without request");
  a_error_data: assert property (s_axi_rvalid && s_axi_rresp == cdp_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule
bind cdp_datapath cdp_datapath_asserts #(.DIV_W(DIV_W)) cdp_datapath_asserts_inst (
  .core_clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// File: bench/cdp_datapath_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// register-level datapath tests
// --------------------------------
module cdp_datapath_tb_top;
  logic core_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;  // d: last word read
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [8:0] sp [4] = '{9'h07f, 9'h080, 9'h0ff, 9'h100};  // edges of the sfr window
  int n_errors = 0;
  int n_tests = 0;
  cdp_datapath cdp_datapath_inst (.core_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, e);
    n_tests++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one transfer; readies sampled mid-cycle so no edge race decides a release
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] v);
    logic ta, tw, tr, dn;
    @(posedge core_clk);
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    s_axi_awaddr <= ad;
    s_axi_araddr <= ad;
    s_axi_wdata <= v;
    do begin
      @(negedge core_clk);
      {ta, tw, tr} = {s_axi_awready, s_axi_wready, s_axi_arready};
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end while (!dn);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] m, e);
    xfer(1'b0, ad, 32'h0);
    chk($sformatf("reg %h", ad), d & m, e);
  endtask
  // load operands, start, poll done, compare the low rw result bits
  task automatic op(input logic [7:0] o, input logic [1:0] z, input logic [31:0] a, b,
      input logic [2:0] s, input int rw, input logic [31:0] e);
    xfer(1'b1, cdp_pkg::ADDR_OPA, a);
    xfer(1'b1, cdp_pkg::ADDR_OPB, b);
    xfer(1'b1, cdp_pkg::ADDR_CTRL, {13'h0, s, 1'b0, s, 2'h0, z, o});
    d = 32'h0;
    for (int i = 0; i < 40 && d[cdp_pkg::FL_DONE] !== 1'b1; i++)
      xfer(1'b0, cdp_pkg::ADDR_FLAGS, 32'h0);
    chk("done", {31'h0, d[cdp_pkg::FL_DONE]}, 32'h1);
    rc(cdp_pkg::ADDR_RES, 32'((64'h1 << rw) - 64'h1), e);
  endtask
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rc(cdp_pkg::ADDR_XRS, 32'hff, 32'h1);
    op(cdp_pkg::CDP_OP_DISP16, 2'h1, 32'h2005, 32'hf000, 3'h0, 0, 32'h0);
    rc(cdp_pkg::ADDR_ADDR, 32'hffffff, 32'h1005);
    op(cdp_pkg::CDP_OP_DISP24, 2'h2, 32'h12005, 32'hf000, 3'h0, 0, 32'h0);
    rc(cdp_pkg::ADDR_ADDR, 32'hffffff, 32'h11005);
    op(cdp_pkg::CDP_OP_MUL, 2'h1, 32'hffff, 32'hffff, 3'h0, 32, 32'hfffe0001);
    op(cdp_pkg::CDP_OP_CMP, 2'h0, 32'h3, 32'h5, 3'h0, 32, 32'hfffe0001);
    rc(cdp_pkg::ADDR_FLAGS, 32'h1f, 32'hd);
    op(cdp_pkg::CDP_OP_DIV, 2'h1, 32'hffff, 32'h10, 3'h0, 32, 32'hf0fff);
    op(cdp_pkg::CDP_OP_DIV, 2'h0, 32'h12, 32'h0, 3'h0, 0, 32'h0);
    rc(cdp_pkg::ADDR_FLAGS, 32'h2, 32'h2);
    op(cdp_pkg::CDP_OP_INC, 2'h2, 32'hfffffffe, 32'h0, 3'h4, 32, 32'h2);
    op(cdp_pkg::CDP_OP_XOR, 2'h1, 32'hf0f, 32'hf0f0, 3'h0, 16, 32'hffff);
    rc(cdp_pkg::ADDR_FLAGS, 32'h18, 32'h8);
    op(cdp_pkg::CDP_OP_SRA, 2'h0, 32'h81, 32'h0, 3'h0, 8, 32'hc0);
    op(cdp_pkg::CDP_OP_HIGHW, 2'h2, 32'h12345678, 32'habcd, 3'h0, 32, 32'habcd5678);
    op(cdp_pkg::CDP_OP_BCLR, 2'h0, 32'hf0, 32'h0, 3'h7, 8, 32'h70);
    op(cdp_pkg::CDP_OP_DEC, 2'h0, 32'h1, 32'h0, 3'h2, 32, 32'hff);
    op(cdp_pkg::CDP_OP_MUL, 2'h0, 32'hff, 32'hff, 3'h0, 32, 32'hfe01);
    op(cdp_pkg::CDP_OP_DIV, 2'h0, 32'h64, 32'h7, 3'h0, 32, 32'h20e);
    op(cdp_pkg::CDP_OP_SLL, 2'h1, 32'h8001, 32'h0, 3'h0, 32, 32'h2);
    op(cdp_pkg::CDP_OP_SRL, 2'h0, 32'h81, 32'h0, 3'h0, 32, 32'h40);
    op(cdp_pkg::CDP_OP_XMOVE, 2'h0, 32'h1a5, 32'h1234, 3'h0, 32, 32'ha5);
    rc(cdp_pkg::ADDR_ADDR, 32'hffffff, 32'h11234);
    op(cdp_pkg::CDP_OP_CMOVE, 2'h0, 32'h5a, 32'h5678, 3'h0, 32, 32'h5a);
    rc(cdp_pkg::ADDR_ADDR, 32'hffffff, 32'hff5678);
    op(cdp_pkg::CDP_OP_SEXT, 2'h1, 32'h180, 32'h0, 3'h0, 32, 32'hff80);
    op(cdp_pkg::CDP_OP_ZEXT, 2'h1, 32'h180, 32'h0, 3'h0, 32, 32'h80);
    op(cdp_pkg::CDP_OP_NIBX, 2'h0, 32'h12, 32'h34, 3'h0, 32, 32'h1432);
    op(cdp_pkg::CDP_OP_POP, 2'h2, 32'h12345678, 32'h0, 3'h0, 32, 32'h5678);
    op(cdp_pkg::CDP_OP_BTOC, 2'h0, 32'h0, 32'h0, 3'h3, 0, 32'h0);
    rc(cdp_pkg::ADDR_FLAGS, 32'h1, 32'h0);
    op(cdp_pkg::CDP_OP_BORN, 2'h0, 32'h0, 32'h0, 3'h3, 0, 32'h0);
    rc(cdp_pkg::ADDR_FLAGS, 32'h1, 32'h1);
    op(cdp_pkg::CDP_OP_CTOB, 2'h0, 32'h0, 32'h0, 3'h5, 32, 32'h20);
    foreach (sp[i]) begin
      xfer(1'b1, cdp_pkg::ADDR_SFR, {23'h0, sp[i]});
      rc(cdp_pkg::ADDR_SFR, 32'h80000000, {i == 1 || i == 2, 31'h0});
    end
    rc(8'h20, 32'hffffffff, 32'h0);
    chk("rresp", {30'h0, r}, {30'h0, cdp_pkg::RESP_SLVERR});
    stop_test();
  end
endmodule
`default_nettype wire

// File: hw/cdp_datapath.sv
// Summary of operation
// - word base plus signed offset, 16-bit wrap
// - dword base plus signed offset, 24 bits
// - compare sets flags, stores no difference
// - inc/dec byte, word, dword by 1,2,4
// - unsigned multiply and divide, 8 and 16
// - product fills next-wider register
// - quotient low half, remainder high half
// - zero divisor sets overflow flag
// - and/or/xor update zero and negative
// - left shift loads zero at lsb
// - logical right shift loads zero at msb
// - arithmetic right shift keeps msb, byte and word only
// - external move uses region select, resets 01
// - code move reads from region ff
// - extending move fills sign or zeros
// - high word load writes upper half
// - nibble exchange swaps only low nibbles
// - push byte/word/dword, pop byte/word only
// - set/clear/invert bit, and/or into carry
// - move bit to carry and back
// - sfr decode only in 080 to 0ff
`timescale 1ns/1ps
`default_nettype none
module cdp_datapath #(
  parameter int DIV_W = 16  // widest divide, one quotient bit per cycle
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // byte-lane merge, shared by the operand and control registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // mask a value to the operand size
  function automatic logic [31:0] fit(input logic [31:0] v, input cdp_pkg::cdp_size_t s);
    if (s == cdp_pkg::CDP_SZ_BYTE) begin
      return {24'h0, v[7:0]};
    end else if (s == cdp_pkg::CDP_SZ_WORD) begin
      return {16'h0, v[15:0]};
    end else begin
      return v;
    end
  endfunction

  // sign bit of a value at the operand size
  function automatic logic msb(input logic [31:0] v, input cdp_pkg::cdp_size_t s);
    if (s == cdp_pkg::CDP_SZ_BYTE) begin
      return v[7];
    end else if (s == cdp_pkg::CDP_SZ_WORD) begin
      return v[15];
    end else begin
      return v[31];
    end
  endfunction

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [31:0] opa_reg;  // operand a
  logic [31:0] opb_reg;  // operand b
  logic [31:0] ctrl_reg;  // last control word that started an operation
  logic [31:0] res_reg;  // result
  logic [4:0] flags_reg;  // cy ov ac n z
  logic done_reg;  // result valid
  logic [7:0] xrs_reg;  // external region select
  logic [23:0] addr_reg;  // computed operand address
  logic sfr_hit_reg;  // last sfr probe decoded
  logic [31:0] sfr_probe_reg;  // last probed sfr address
  cdp_pkg::cdp_state_t state_reg;
  logic [DIV_W-1:0] dq_reg;  // dividend shifting into quotient
  logic [DIV_W-1:0] drem_reg;  // partial remainder
  logic [DIV_W-1:0] dvs_reg;  // divisor
  logic [4:0] dcnt_reg;  // bits still to produce
  cdp_pkg::cdp_size_t sz_div_reg;  // size of the divide in flight

  // -----------------------------------------------------------------
  // axi4-lite handshakes
  // -----------------------------------------------------------------
  logic aw_hold_reg;  // write address taken, waiting for data
  logic w_hold_reg;  // write data taken, waiting for address
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;  // both halves present this cycle
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;  // write address is mapped

  // one write at a time: channels stall while a response is pending
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  assign wr_addr = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_hold_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_hold_reg ? w_strb_reg : s_axi_wstrb;
  assign wr_fire = (aw_hold_reg || (s_axi_awvalid && s_axi_awready)) &&
                   (w_hold_reg || (s_axi_wvalid && s_axi_wready));

  // address decode of writable registers
  always_comb begin
    if (wr_addr == cdp_pkg::ADDR_OPA) begin
      wr_ok = 1'b1;
    end else if (wr_addr == cdp_pkg::ADDR_OPB) begin
      wr_ok = 1'b1;
    end else if (wr_addr == cdp_pkg::ADDR_CTRL) begin
      wr_ok = 1'b1;
    end else if (wr_addr == cdp_pkg::ADDR_XRS) begin
      wr_ok = 1'b1;
    end else if (wr_addr == cdp_pkg::ADDR_SFR) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // write channel capture and response
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cdp_pkg::RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? cdp_pkg::RESP_OKAY : cdp_pkg::RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // read channel: one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cdp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cdp_pkg::RESP_OKAY;
      if (s_axi_araddr == cdp_pkg::ADDR_OPA) begin
        s_axi_rdata <= opa_reg;
      end else if (s_axi_araddr == cdp_pkg::ADDR_OPB) begin
        s_axi_rdata <= opb_reg;
      end else if (s_axi_araddr == cdp_pkg::ADDR_CTRL) begin
        s_axi_rdata <= ctrl_reg;
      end else if (s_axi_araddr == cdp_pkg::ADDR_RES) begin
        s_axi_rdata <= res_reg;
      end else if (s_axi_araddr == cdp_pkg::ADDR_FLAGS) begin
        s_axi_rdata <= {23'h0, done_reg, 3'h0, flags_reg};
      end else if (s_axi_araddr == cdp_pkg::ADDR_XRS) begin
        s_axi_rdata <= {24'h0, xrs_reg};
      end else if (s_axi_araddr == cdp_pkg::ADDR_SFR) begin
        s_axi_rdata <= {sfr_hit_reg, sfr_probe_reg[30:0]};
      end else if (s_axi_araddr == cdp_pkg::ADDR_ADDR) begin
        s_axi_rdata <= {8'h00, addr_reg};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= cdp_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // operand and configuration registers
  // -----------------------------------------------------------------
  logic start;  // control word written: launch the operation
  // only from idle, else the finishing divide would swallow the launch
  assign start = wr_fire && (wr_addr == cdp_pkg::ADDR_CTRL) && (state_reg == cdp_pkg::CDP_ST_IDLE);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      opa_reg <= 32'h0000_0000;
      opb_reg <= 32'h0000_0000;
      ctrl_reg <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (wr_addr == cdp_pkg::ADDR_OPA) begin
        opa_reg <= merge(opa_reg, wr_data, wr_strb);
      end else if (wr_addr == cdp_pkg::ADDR_OPB) begin
        opb_reg <= merge(opb_reg, wr_data, wr_strb);
      end else if (start) begin
        ctrl_reg <= merge(ctrl_reg, wr_data, wr_strb);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      xrs_reg <= cdp_pkg::XRS_RESET;
    end else if (wr_fire && wr_addr == cdp_pkg::ADDR_XRS && wr_strb[0]) begin
      xrs_reg <= wr_data[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sfr_probe_reg <= 32'h0000_0000;
      sfr_hit_reg <= 1'b0;
    end else if (wr_fire && wr_addr == cdp_pkg::ADDR_SFR) begin
      sfr_probe_reg <= wr_data;
      sfr_hit_reg <= (wr_data[31:9] == 23'h0) && (wr_data[8:0] >= cdp_pkg::SFR_LO) &&
                     (wr_data[8:0] <= cdp_pkg::SFR_HI);
    end
  end

  // -----------------------------------------------------------------
  // combinational execution
  // -----------------------------------------------------------------
  // decode fields of the incoming control word
  cdp_pkg::cdp_op_t op;
  cdp_pkg::cdp_size_t sz;
  logic [2:0] bidx;  // bit index for bit ops
  logic [2:0] step;  // inc/dec step
  logic [31:0] a;
  logic [31:0] b;
  assign op = cdp_pkg::cdp_op_t'(wr_data[cdp_pkg::CTRL_OP_LSB +: 8]);
  assign sz = cdp_pkg::cdp_size_t'(wr_data[cdp_pkg::CTRL_SZ_LSB +: 2]);
  assign bidx = wr_data[cdp_pkg::CTRL_BIT_LSB +: 3];
  assign step = wr_data[cdp_pkg::CTRL_STEP_LSB +: 3];
  assign a = opa_reg;
  assign b = opb_reg;

  logic [31:0] x_res;  // next result
  logic [4:0] x_fl;  // next flags
  logic [23:0] x_addr;  // next address
  logic x_store;  // result register written
  logic [32:0] sum;  // wide add/sub
  logic [4:0] nib;  // low-nibble add/sub for aux carry
  logic [31:0] stp;  // decoded step

  always_comb begin
    x_res = res_reg;
    x_fl = flags_reg;
    x_addr = addr_reg;
    x_store = 1'b1;
    sum = 33'h0;
    nib = 5'h0;
    stp = (step == 3'h4) ? 32'h4 : ((step == 3'h2) ? 32'h2 : 32'h1);
    case (op)
      cdp_pkg::CDP_OP_DISP16: begin
        x_addr = {8'h00, a[15:0] + b[15:0]};
        x_res = {8'h00, x_addr};
      end
      cdp_pkg::CDP_OP_DISP24: begin
        x_addr = a[23:0] + {{8{b[15]}}, b[15:0]};
        x_res = {8'h00, x_addr};
      end
      cdp_pkg::CDP_OP_ADD, cdp_pkg::CDP_OP_SUB, cdp_pkg::CDP_OP_CMP: begin
        if (op == cdp_pkg::CDP_OP_ADD) begin
          sum = {1'b0, fit(a, sz)} + {1'b0, fit(b, sz)};
          nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        end else begin
          sum = {1'b0, fit(a, sz)} - {1'b0, fit(b, sz)};
          nib = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        end
        x_fl[cdp_pkg::FL_CY] = (sz == cdp_pkg::CDP_SZ_BYTE) ? sum[8] : sum[16];
        x_fl[cdp_pkg::FL_AC] = nib[4];
        x_fl[cdp_pkg::FL_N] = msb(sum[31:0], sz);
        x_fl[cdp_pkg::FL_Z] = (fit(sum[31:0], sz) == 32'h0);
        x_fl[cdp_pkg::FL_OV] = (op == cdp_pkg::CDP_OP_ADD) ?
          (msb(a, sz) == msb(b, sz)) && (msb(sum[31:0], sz) != msb(a, sz)) :
          (msb(a, sz) != msb(b, sz)) && (msb(sum[31:0], sz) != msb(a, sz));
        x_res = fit(sum[31:0], sz);
        x_store = (op != cdp_pkg::CDP_OP_CMP);
      end
      // step of 1, 2 or 4
      cdp_pkg::CDP_OP_INC: x_res = fit(a + stp, sz);
      cdp_pkg::CDP_OP_DEC: x_res = fit(a - stp, sz);
      cdp_pkg::CDP_OP_MUL: begin
        if (sz == cdp_pkg::CDP_SZ_BYTE) begin
          x_res = {16'h0, 16'(a[7:0]) * 16'(b[7:0])};
        end else begin
          x_res = a[15:0] * b[15:0];
        end
      end
      // logic ops set z and n
      cdp_pkg::CDP_OP_AND, cdp_pkg::CDP_OP_OR, cdp_pkg::CDP_OP_XOR: begin
        if (op == cdp_pkg::CDP_OP_AND) begin
          x_res = fit(a & b, sz);
        end else if (op == cdp_pkg::CDP_OP_OR) begin
          x_res = fit(a | b, sz);
        end else begin
          x_res = fit(a ^ b, sz);
        end
        x_fl[cdp_pkg::FL_Z] = (x_res == 32'h0);
        x_fl[cdp_pkg::FL_N] = msb(x_res, sz);
      end
      cdp_pkg::CDP_OP_SLL: x_res = fit({a[30:0], 1'b0}, sz);
      cdp_pkg::CDP_OP_SRL: x_res = fit(a, sz) >> 1;
      cdp_pkg::CDP_OP_SRA: begin
        x_res = fit(a, sz) >> 1;
        if (sz == cdp_pkg::CDP_SZ_BYTE) begin
          x_res[7] = a[7];
        end else begin
          x_res[15] = a[15];
        end
      end
      cdp_pkg::CDP_OP_XMOVE: begin
        x_addr = {xrs_reg, b[15:0]};
        x_res = {24'h0, a[7:0]};
      end
      cdp_pkg::CDP_OP_CMOVE: begin
        x_addr = {cdp_pkg::CODE_REGION, b[15:0]};
        x_res = {24'h0, a[7:0]};
      end
      cdp_pkg::CDP_OP_SEXT: x_res = {16'h0, {8{a[7]}}, a[7:0]};
      cdp_pkg::CDP_OP_ZEXT: x_res = {24'h0, a[7:0]};
      cdp_pkg::CDP_OP_HIGHW: x_res = {b[15:0], a[15:0]};
      cdp_pkg::CDP_OP_NIBX: x_res = {16'h0, a[7:4], b[3:0], b[7:4], a[3:0]};
      cdp_pkg::CDP_OP_SWAP: x_res = {fit(b, sz) == fit(b, sz) ? 16'h0 : 16'h0, b[7:0], a[7:0]};
      cdp_pkg::CDP_OP_PUSH: x_res = fit(a, sz);
      cdp_pkg::CDP_OP_POP: begin
        x_res = (sz == cdp_pkg::CDP_SZ_BYTE) ? fit(a, sz) : fit(a, cdp_pkg::CDP_SZ_WORD);
      end
      cdp_pkg::CDP_OP_BSET: x_res = {24'h0, a[7:0] | (8'h01 << bidx)};
      cdp_pkg::CDP_OP_BCLR: x_res = {24'h0, a[7:0] & ~(8'h01 << bidx)};
      cdp_pkg::CDP_OP_BCPL: x_res = {24'h0, a[7:0] ^ (8'h01 << bidx)};
      cdp_pkg::CDP_OP_BAND: begin
        x_fl[cdp_pkg::FL_CY] = flags_reg[cdp_pkg::FL_CY] & a[bidx];
        x_store = 1'b0;
      end
      cdp_pkg::CDP_OP_BANDN: begin
        x_fl[cdp_pkg::FL_CY] = flags_reg[cdp_pkg::FL_CY] & ~a[bidx];
        x_store = 1'b0;
      end
      cdp_pkg::CDP_OP_BOR: begin
        x_fl[cdp_pkg::FL_CY] = flags_reg[cdp_pkg::FL_CY] | a[bidx];
        x_store = 1'b0;
      end
      cdp_pkg::CDP_OP_BORN: begin
        x_fl[cdp_pkg::FL_CY] = flags_reg[cdp_pkg::FL_CY] | ~a[bidx];
        x_store = 1'b0;
      end
      cdp_pkg::CDP_OP_BTOC: begin
        x_fl[cdp_pkg::FL_CY] = a[bidx];
        x_store = 1'b0;
      end
      cdp_pkg::CDP_OP_CTOB: begin
        x_res = {24'h0, a[7:0]};
        x_res[bidx] = flags_reg[cdp_pkg::FL_CY];
      end
      default: x_store = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // result, flags and divider sequencing
  // -----------------------------------------------------------------
  // restoring divide step: shift, trial subtract
  logic [DIV_W:0] trial;
  assign trial = {drem_reg, dq_reg[DIV_W-1]} - {1'b0, dvs_reg};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= cdp_pkg::CDP_ST_IDLE;
      res_reg <= 32'h0000_0000;
      flags_reg <= 5'h00;
      done_reg <= 1'b0;
      addr_reg <= 24'h00_0000;
      dq_reg <= '0;
      drem_reg <= '0;
      dvs_reg <= '0;
      dcnt_reg <= 5'h00;
    end else begin
      case (state_reg)
        cdp_pkg::CDP_ST_DIV: begin
          // a byte divide runs with zero-padded operands, same result
          drem_reg <= trial[DIV_W] ? {drem_reg[DIV_W-2:0], dq_reg[DIV_W-1]} : trial[DIV_W-1:0];
          dq_reg <= {dq_reg[DIV_W-2:0], ~trial[DIV_W]};
          dcnt_reg <= dcnt_reg - 5'h01;
          if (dcnt_reg == 5'h01) begin
            state_reg <= cdp_pkg::CDP_ST_DONE;
          end
        end
        cdp_pkg::CDP_ST_DONE: begin
          if (sz_div_reg == cdp_pkg::CDP_SZ_BYTE) begin
            res_reg <= {16'h0, drem_reg[7:0], dq_reg[7:0]};
          end else begin
            res_reg <= {drem_reg[15:0], dq_reg[15:0]};
          end
          done_reg <= 1'b1;
          state_reg <= cdp_pkg::CDP_ST_IDLE;
        end
        default: begin
          if (start) begin
            done_reg <= 1'b0;
            if (op == cdp_pkg::CDP_OP_DIV) begin
              if (fit(b, sz) == 32'h0) begin
                flags_reg[cdp_pkg::FL_OV] <= 1'b1;
                done_reg <= 1'b1;
              end else begin
                flags_reg[cdp_pkg::FL_OV] <= 1'b0;
                dq_reg <= DIV_W'(fit(a, sz));
                drem_reg <= '0;
                dvs_reg <= DIV_W'(fit(b, sz));
                dcnt_reg <= 5'(DIV_W);
                state_reg <= cdp_pkg::CDP_ST_DIV;
              end
            end else begin
              flags_reg <= x_fl;
              addr_reg <= x_addr;
              if (x_store) begin
                res_reg <= x_res;
              end
              done_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // size of the divide in flight
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sz_div_reg <= cdp_pkg::CDP_SZ_BYTE;
    end else if (start && op == cdp_pkg::CDP_OP_DIV) begin
      sz_div_reg <= sz;
    end
  end
endmodule
`default_nettype wire

// File: hw/cdp_pkg.sv
package cdp_pkg;
  // -----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_OPA = 8'h00;   // operand a
  localparam logic [7:0] ADDR_OPB = 8'h04;   // operand b / offset / immediate
  localparam logic [7:0] ADDR_CTRL = 8'h08;  // op, size, bit index; write starts
  localparam logic [7:0] ADDR_RES = 8'h0c;   // result word
  localparam logic [7:0] ADDR_FLAGS = 8'h10; // flags, done
  localparam logic [7:0] ADDR_XRS = 8'h14;   // external region select
  localparam logic [7:0] ADDR_SFR = 8'h18;   // sfr decode probe
  localparam logic [7:0] ADDR_ADDR = 8'h1c;  // computed operand address

  // -----------------------------------------------------------------
  // control field layout
  // -----------------------------------------------------------------
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SZ_LSB = 8;
  localparam int CTRL_BIT_LSB = 12;
  localparam int CTRL_STEP_LSB = 16;

  // flag bit positions in the flag register
  localparam int FL_CY = 0;
  localparam int FL_OV = 1;
  localparam int FL_AC = 2;
  localparam int FL_N = 3;
  localparam int FL_Z = 4;
  localparam int FL_DONE = 8;

  localparam logic [7:0] XRS_RESET = 8'h01;  // external region after reset
  localparam logic [7:0] CODE_REGION = 8'hff; // code memory region
  localparam logic [8:0] SFR_LO = 9'h080;    // implemented sfr window
  localparam logic [8:0] SFR_HI = 9'h0ff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // operand size
  typedef enum logic [1:0] {
    CDP_SZ_BYTE,
    CDP_SZ_WORD,
    CDP_SZ_DWORD
  } cdp_size_t;

  // operations
  typedef enum logic [7:0] {
    CDP_OP_DISP16,
    CDP_OP_DISP24,
    CDP_OP_ADD,
    CDP_OP_SUB,
    CDP_OP_CMP,
    CDP_OP_INC,
    CDP_OP_DEC,
    CDP_OP_MUL,
    CDP_OP_DIV,
    CDP_OP_AND,
    CDP_OP_OR,
    CDP_OP_XOR,
    CDP_OP_SLL,
    CDP_OP_SRL,
    CDP_OP_SRA,
    CDP_OP_XMOVE,
    CDP_OP_CMOVE,
    CDP_OP_SEXT,
    CDP_OP_ZEXT,
    CDP_OP_HIGHW,
    CDP_OP_NIBX,
    CDP_OP_SWAP,
    CDP_OP_PUSH,
    CDP_OP_POP,
    CDP_OP_BSET,
    CDP_OP_BCLR,
    CDP_OP_BCPL,
    CDP_OP_BAND,
    CDP_OP_BANDN,
    CDP_OP_BOR,
    CDP_OP_BORN,
    CDP_OP_BTOC,
    CDP_OP_CTOB
  } cdp_op_t;

  // divider sequencing
  typedef enum logic [1:0] {
    CDP_ST_IDLE,
    CDP_ST_DIV,
    CDP_ST_DONE
  } cdp_state_t;
endpackage
